//--- rtl/wsp_pkg.sv
// shared constants for the wiper setting port, both ends
package wsp_pkg;
	// ****************************************
	// code space
	// ****************************************
	localparam int CODE_W = 7;
	localparam int POSITIONS = 128;
	localparam logic [6:0] CODE_ZERO = 7'h00;
	localparam logic [6:0] CODE_MID = 7'h40;
	localparam logic [6:0] CODE_FULL = 7'h7f;
	// ****************************************
	// addressing
	// ****************************************
	localparam logic [6:0] ADDR_MAIN = 7'h2e;
	localparam logic [6:0] ADDR_ALT1 = 7'h17;
	localparam logic [6:0] ADDR_ALT2 = 7'h16;
	localparam logic [1:0] SEL_MAIN = 2'h0;
	localparam logic [1:0] SEL_ALT1 = 2'h1;
	localparam logic [1:0] SEL_ALT2 = 2'h2;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	// ****************************************
	// controller timing
	// ****************************************
	localparam int CLK_MHZ = 40;
	localparam int SCL_KHZ = 100;
	localparam int QUARTER_CYC = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
	localparam int QW = 8;
endpackage : wsp_pkg

//--- rtl/wsp_if.sv
// two-wire bus joining the controller and the wiper port
`timescale 1ns/1ps
interface wsp_if;
	logic scl_o;
	logic scl_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	// open drain with pull-up: any enabled low driver wins
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_host_oe && !sda_host_o) || (sda_dev_oe && !sda_dev_o));
	modport device (input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe,
		output sda_host_o, output sda_host_oe);
endinterface : wsp_if

//--- rtl/wsp_device.sv
// two-wire target holding the 7-bit wiper setting latch
`timescale 1ns/1ps
module wsp_device #(
	parameter logic [1:0] ADDR_SEL = wsp_pkg::SEL_MAIN
) (
	input wire logic clock,
	input wire logic reset_n,
	wsp_if.device bus,
	output logic [6:0] wiper_setting_latch,
	output logic [7:0] wiper_to_low_end_resistance,
	output logic [7:0] wiper_to_high_end_resistance,
	output logic setting_updated
);
	typedef enum logic [2:0] {
		WSP_IDLE = 3'b000,
		WSP_ADDR = 3'b001,
		WSP_WRITE = 3'b010,
		WSP_READ = 3'b011,
		WSP_IGNORE = 3'b100
	} wsp_state_t;

	// ****************************************
	// pin synchronisers and edge detection
	// ****************************************
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], bus.scl};
			sda_sync <= {sda_sync[0], bus.sda};
			scl_d <= scl_sync[1];
			sda_d <= sda_sync[1];
		end
	end
	assign scl_rise = scl_sync[1] && !scl_d;
	assign scl_fall = !scl_sync[1] && scl_d;
	assign start_seen = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
	assign stop_seen = scl_sync[1] && scl_d && !sda_d && sda_sync[1];

	// ****************************************
	// address choice
	// ****************************************
	logic [6:0] own_addr;
	always_comb begin
		unique case (ADDR_SEL)
			wsp_pkg::SEL_ALT1: own_addr = wsp_pkg::ADDR_ALT1;
			wsp_pkg::SEL_ALT2: own_addr = wsp_pkg::ADDR_ALT2;
			default: own_addr = wsp_pkg::ADDR_MAIN;
		endcase
	end

	// ****************************************
	// byte framing
	// ****************************************
	wsp_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] tx_byte;
	logic ack_drive;
	logic host_acked;
	logic first_fall;
	// the scl fall that ends the start hold carries no bit, so it must not count
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			first_fall <= 1'b0;
		end else if (start_seen) begin
			first_fall <= 1'b1;
		end else if (scl_fall) begin
			first_fall <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt <= wsp_pkg::BIT_ZERO;
		end else if (start_seen || stop_seen) begin
			bit_cnt <= wsp_pkg::BIT_ZERO;
		end else if (scl_fall && !first_fall && state != WSP_IDLE && state != WSP_IGNORE) begin
			// nine pulses per byte, eight data plus ack
			bit_cnt <= (bit_cnt == wsp_pkg::BIT_ACK) ? wsp_pkg::BIT_ZERO : bit_cnt + 4'h1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			shreg <= 8'h00;
		end else if (scl_rise && bit_cnt <= wsp_pkg::BIT_LAST) begin
			// sample on rising edge, where data is stable
			shreg <= {shreg[6:0], sda_sync[1]};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			host_acked <= 1'b0;
		end else if (scl_rise && bit_cnt == wsp_pkg::BIT_ACK) begin
			host_acked <= !sda_sync[1];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= WSP_IDLE;
		end else if (start_seen) begin
			state <= WSP_ADDR;
		end else if (stop_seen) begin
			state <= WSP_IDLE;
		end else if (scl_fall && bit_cnt == wsp_pkg::BIT_ACK) begin
			unique case (state)
				WSP_ADDR: begin
					if (shreg[7:1] != own_addr) begin
						state <= WSP_IGNORE;
					end else if (shreg[0] == wsp_pkg::DIR_READ) begin
						state <= WSP_READ;
					end else begin
						state <= WSP_WRITE;
					end
				end
				// a nack ends the read; the bus is left alone until stop or start
				WSP_READ: state <= host_acked ? WSP_READ : WSP_IGNORE;
				default: state <= state;
			endcase
		end
	end

	// ****************************************
	// setting latch
	// ****************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wiper_setting_latch <= wsp_pkg::CODE_MID;
			setting_updated <= 1'b0;
		end else begin
			setting_updated <= 1'b0;
			// load at end of the eighth bit, before the ack pulse
			if (state == WSP_WRITE && scl_fall && bit_cnt == wsp_pkg::BIT_LAST) begin
				wiper_setting_latch <= shreg[6:0];
				setting_updated <= 1'b1;
			end
		end
	end

	// tap position: low-end grows with code, high-end is its complement to 128
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			wiper_to_low_end_resistance <= {1'b0, wsp_pkg::CODE_MID};
			wiper_to_high_end_resistance <= {1'b0, wsp_pkg::CODE_MID};
		end else begin
			wiper_to_low_end_resistance <= {1'b0, wiper_setting_latch};
			wiper_to_high_end_resistance <= 8'(wsp_pkg::POSITIONS) - {1'b0, wiper_setting_latch};
		end
	end

	// ****************************************
	// data line drive, changed only on scl low
	// ****************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_byte <= 8'h00;
		end else if (scl_fall && bit_cnt == wsp_pkg::BIT_ACK) begin
			tx_byte <= {1'b0, wiper_setting_latch};
		end else if (scl_fall && state == WSP_READ && bit_cnt < wsp_pkg::BIT_LAST) begin
			tx_byte <= {tx_byte[6:0], 1'b0};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ack_drive <= 1'b0;
		end else if (start_seen || stop_seen) begin
			ack_drive <= 1'b0;
		end else if (scl_fall) begin
			ack_drive <= bit_cnt == wsp_pkg::BIT_LAST && ((state == WSP_ADDR
				&& shreg[7:1] == own_addr) || state == WSP_WRITE);
		end
	end

	// open drain: enable only to pull low
	logic read_drive;
	logic read_bit_phase;
	assign read_bit_phase = state == WSP_READ && bit_cnt <= wsp_pkg::BIT_LAST;
	assign read_drive = read_bit_phase && !tx_byte[7];
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			bus.sda_dev_o <= 1'b1;
			bus.sda_dev_oe <= 1'b0;
		end else begin
			bus.sda_dev_o <= 1'b0;
			bus.sda_dev_oe <= ack_drive || read_drive;
		end
	end
endmodule : wsp_device

//--- rtl/wsp_host.sv
// two-wire controller issuing one write or one read of the setting
`timescale 1ns/1ps
module wsp_host #(
	parameter logic [6:0] TARGET_ADDR = wsp_pkg::ADDR_MAIN,
	parameter int QUARTER = wsp_pkg::QUARTER_CYC
) (
	input wire logic clock,
	input wire logic reset_n,
	wsp_if.host bus,
	input wire logic req_valid,
	input wire logic req_read,
	input wire logic [6:0] req_code,
	output logic busy,
	output logic done,
	output logic nack,
	output logic [6:0] read_code
);
	typedef enum logic [2:0] {
		WSH_IDLE = 3'b000,
		WSH_START = 3'b001,
		WSH_BITS = 3'b010,
		WSH_STOP = 3'b011,
		WSH_DONE = 3'b100
	} wsh_state_t;

	wsh_state_t state;
	logic [wsp_pkg::QW-1:0] tick_cnt;
	logic [1:0] phase;
	logic [4:0] bit_idx;
	logic [17:0] frame;
	logic is_read;
	logic [1:0] sda_sync;
	logic tick;
	assign tick = tick_cnt == wsp_pkg::QW'(QUARTER - 1);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sda_sync <= 2'h3;
		end else begin
			sda_sync <= {sda_sync[0], bus.sda};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= (tick || state == WSH_IDLE) ? '0 : tick_cnt + 1'b1;
		end
	end

	// ****************************************
	// sequencer: four quarters per bit, data moves in quarter 0 (scl low)
	// ****************************************
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= WSH_IDLE;
			phase <= 2'h0;
			bit_idx <= 5'h00;
			frame <= 18'h00000;
			is_read <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			nack <= 1'b0;
			read_code <= 7'h00;
			bus.scl_o <= 1'b1;
			bus.scl_oe <= 1'b0;
			bus.sda_host_o <= 1'b1;
			bus.sda_host_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (state)
				WSH_IDLE: begin
					if (req_valid) begin
						// address, direction, ack slot, data byte, ack slot
						frame <= {TARGET_ADDR, req_read, 1'b1, 1'b0, req_code, 1'b1};
						is_read <= req_read;
						nack <= 1'b0;
						busy <= 1'b1;
						phase <= 2'h0;
						bit_idx <= 5'h00;
						state <= WSH_START;
					end
				end
				WSH_START: if (tick) begin
					phase <= phase + 2'h1;
					if (phase == 2'h0) begin
						bus.sda_host_oe <= 1'b1;
						bus.sda_host_o <= 1'b0;
					end else if (phase == 2'h1) begin
						bus.scl_oe <= 1'b1;
						bus.scl_o <= 1'b0;
						phase <= 2'h0;
						state <= WSH_BITS;
					end
				end
				WSH_BITS: if (tick) begin
					phase <= phase + 2'h1;
					unique case (phase)
						2'h0: begin
							// release for 1 bits (ack slots included) and for read data, else pull low
							bus.sda_host_oe <= !(frame[17] || (is_read && bit_idx > 5'd8));
							bus.sda_host_o <= 1'b0;
						end
						2'h1: bus.scl_o <= 1'b1;
						2'h2: begin
							if (bit_idx == 5'd8 && sda_sync[1]) begin
								nack <= 1'b1;
							end
							if (is_read && bit_idx > 5'd8 && bit_idx < 5'd17) begin
								read_code <= {read_code[5:0], sda_sync[1]};
							end
						end
						default: begin
							bus.scl_o <= 1'b0;
							frame <= {frame[16:0], 1'b1};
							bit_idx <= bit_idx + 5'h01;
							if (bit_idx == 5'd17 || (bit_idx == 5'd8 && nack)) begin
								state <= WSH_STOP;
							end
						end
					endcase
				end
				WSH_STOP: if (tick) begin
					phase <= phase + 2'h1;
					unique case (phase)
						2'h0: begin
							bus.sda_host_oe <= 1'b1;
							bus.sda_host_o <= 1'b0;
						end
						2'h1: bus.scl_oe <= 1'b0;
						2'h2: bus.sda_host_oe <= 1'b0;
						default: state <= WSH_DONE;
					endcase
				end
				default: begin
					busy <= 1'b0;
					done <= 1'b1;
					state <= WSH_IDLE;
				end
			endcase
		end
	end
endmodule : wsp_host

//--- verif/wsp_chk.sv
// wire-level assertions for the wiper setting port bus
`timescale 1ns/1ps
module wsp_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	// ****************************************
	// pulse count since the last start
	// ****************************************
	logic scl_q;
	logic sda_q;
	logic [4:0] rise_cnt;
	logic dir;
	logic dev_low;
	logic host_low;
	logic start;
	logic stop;
	logic scl_rise;
	assign dev_low = sda_dev_oe && !sda_dev_o;
	assign host_low = sda_host_oe && !sda_host_o;
	assign start = scl && scl_q && sda_q && !sda;
	assign stop = scl && scl_q && !sda_q && sda;
	assign scl_rise = scl && !scl_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end
	// saturates so a long idle bus never wraps back into the address phase
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rise_cnt <= 5'h00;
		end else if (start) begin
			rise_cnt <= 5'h00;
		end else if (scl_rise && rise_cnt != 5'h1f) begin
			rise_cnt <= rise_cnt + 5'h01;
		end
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dir <= 1'b0;
		end else if (scl_rise && rise_cnt == 5'h07) begin
			dir <= sda;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// ****************************************
	// properties
	// ****************************************
	property p_addr_quiet;
		dev_low |-> rise_cnt >= 5'h08;
	endproperty
	property p_addr_ack;
		scl_rise && rise_cnt == 5'h08 |-> !sda;
	endproperty
	property p_write_ack;
		scl_rise && rise_cnt == 5'h11 && !dir |-> !sda;
	endproperty
	property p_read_top_zero;
		scl_rise && rise_cnt == 5'h09 && dir |-> !sda;
	endproperty
	property p_read_nack;
		scl_rise && rise_cnt == 5'h11 && dir |-> sda;
	endproperty
	property p_dev_stable;
		scl && scl_q |-> $stable(dev_low);
	endproperty
	property p_host_stable;
		scl && scl_q && $changed(host_low) |-> rise_cnt == 5'h00 || rise_cnt == 5'h13;
	endproperty
	property p_quiet_after_stop;
		stop |-> !dev_low [*8];
	endproperty
	// a stop only comes after the full address byte, data byte, both ack pulses and the nineteenth rise
	property p_stop_after_byte;
		stop |-> rise_cnt == 5'h13;
	endproperty
	a_addr_quiet: assert property (p_addr_quiet) else $error("device drove sda in address");
	a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
	a_write_ack: assert property (p_write_ack) else $error("data byte not acked");
	a_read_top_zero: assert property (p_read_top_zero) else $error("read top bit not 0");
	a_read_nack: assert property (p_read_nack) else $error("read ninth pulse low");
	a_dev_stable: assert property (p_dev_stable) else $error("device sda moved, scl high");
	a_host_stable: assert property (p_host_stable) else $error("host sda moved, scl high");
	a_quiet_after_stop: assert property (p_quiet_after_stop) else $error("drive after stop");
	a_stop_after_byte: assert property (p_stop_after_byte) else $error("stop out of place");
	c_write: cover property (scl_rise && rise_cnt == 5'h11 && !dir && !sda);
	c_read: cover property (scl_rise && rise_cnt == 5'h11 && dir && sda);
	c_stop: cover property (stop);
endmodule : wsp_chk

//--- verif/wsp_bench.sv
// self-checking bench for the wiper setting port, both ends
`timescale 1ns/1ps
module wsp_bench;
	// short quarter keeps each full frame near 800 cycles, a frame nacked at the address near 420
	localparam int QUARTER = 10;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic req_valid = 1'b0;
	logic req_valid2 = 1'b0;
	logic req_read = 1'b0;
	logic [6:0] req_code = 7'h00;
	logic busy, done, nack, busy2, done2, nack2, updated;
	logic [6:0] read_code, latch, latch2;
	logic [7:0] low_end, high_end;
	logic [6:0] codes [4] = '{wsp_pkg::CODE_ZERO, wsp_pkg::CODE_FULL, wsp_pkg::CODE_MID, 7'h55};
	int bad_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int updates = 0;
	wsp_if bus_a();
	wsp_if bus_b();
	wsp_device #(.ADDR_SEL(wsp_pkg::SEL_MAIN)) wsp_device_i (.clock(clock), .reset_n(reset_n),
		.bus(bus_a.device), .wiper_setting_latch(latch), .wiper_to_low_end_resistance(low_end),
		.wiper_to_high_end_resistance(high_end), .setting_updated(updated));
	wsp_host #(.TARGET_ADDR(wsp_pkg::ADDR_MAIN), .QUARTER(QUARTER)) wsp_host_i (.clock(clock),
		.reset_n(reset_n), .bus(bus_a.host), .req_valid(req_valid), .req_read(req_read),
		.req_code(req_code), .busy(busy), .done(done), .nack(nack), .read_code(read_code));
	// second pair: alternate addresses one bit apart, so no ack may come
	wsp_device #(.ADDR_SEL(wsp_pkg::SEL_ALT2)) wsp_device_b_i (.clock(clock), .reset_n(reset_n),
		.bus(bus_b.device), .wiper_setting_latch(latch2), .wiper_to_low_end_resistance(),
		.wiper_to_high_end_resistance(), .setting_updated());
	wsp_host #(.TARGET_ADDR(wsp_pkg::ADDR_ALT1), .QUARTER(QUARTER)) wsp_host_b_i (.clock(clock),
		.reset_n(reset_n), .bus(bus_b.host), .req_valid(req_valid2), .req_read(req_read),
		.req_code(req_code), .busy(busy2), .done(done2), .nack(nack2), .read_code());
	wsp_chk wsp_chk_i (.clock(clock), .reset_n(reset_n), .scl_o(bus_a.scl_o),
		.scl_oe(bus_a.scl_oe), .sda_host_o(bus_a.sda_host_o), .sda_host_oe(bus_a.sda_host_oe),
		.sda_dev_o(bus_a.sda_dev_o), .sda_dev_oe(bus_a.sda_dev_oe), .scl(bus_a.scl),
		.sda(bus_a.sda));
	always #12.5 clock = !clock;
	always @(posedge clock) begin
		cycles++;
		if (updated === 1'b1) begin
			updates++;
		end
		if (cycles == 30000) begin
			bad_count++;
			stop_test();
		end
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic xfer(input logic sel, input logic rd, input logic [6:0] code);
		int n;
		n = 0;
		@(posedge clock) #1;
		req_read = rd;
		req_code = code;
		req_valid = !sel;
		req_valid2 = sel;
		while ((sel ? busy2 : busy) !== 1'b1 && n < 10) begin
			@(posedge clock) #1;
			n++;
		end
		req_valid = 1'b0;
		req_valid2 = 1'b0;
		while ((sel ? done2 : done) !== 1'b1 && n < 3000) begin
			@(posedge clock) #1;
			n++;
		end
		if (n >= 3000) begin
			bad_count++;
		end
	endtask : xfer
	task automatic write_chk(input logic [6:0] code);
		xfer(1'b0, 1'b0, code);
		check({7'h00, nack}, 8'h00);
		check({1'b0, latch}, {1'b0, code});
		check(low_end, {1'b0, code});
		check(high_end, 8'h80 - {1'b0, code});
	endtask : write_chk
	task automatic read_chk(input logic [6:0] exp);
		xfer(1'b0, 1'b1, 7'h00);
		check({7'h00, nack}, 8'h00);
		check({1'b0, read_code}, {1'b0, exp});
	endtask : read_chk
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (12) @(posedge clock);
		#1 reset_n = 1'b1;
		repeat (2) @(posedge clock);
		check({1'b0, latch}, {1'b0, wsp_pkg::CODE_MID});
		check(high_end, 8'h40);
		read_chk(wsp_pkg::CODE_MID);
		$display("test preset done");
		foreach (codes[i]) begin
			write_chk(codes[i]);
			read_chk(codes[i]);
		end
		$display("test write read done");
		read_chk(7'h55);
		read_chk(7'h55);
		check(updates[7:0], 8'h04);
		$display("test repeat read done");
		xfer(1'b1, 1'b0, 7'h11);
		check({7'h00, nack2}, 8'h01);
		check({1'b0, latch2}, {1'b0, wsp_pkg::CODE_MID});
		xfer(1'b1, 1'b1, 7'h00);
		check({7'h00, nack2}, 8'h01);
		$display("test foreign address done");
		stop_test();
	end
endmodule : wsp_bench
